// ### src/gpo_ctrl.sv
// Purpose: Output enable/level commands and interrupt source selection
// Assumes: Command link on its own clock; events and flag clears on clk_in
// Notes:   Command fields held stable by the link side until acknowledged
`timescale 1ns/1ps
`default_nettype none
module gpo_ctrl (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        link_clk_in,
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic [7:0]  cmd_arg_in,
    input  wire logic [15:0] prop_index_in,
    input  wire logic [15:0] prop_data_in,
    output logic      [7:0]  status_out,
    output logic      [15:0] prop_rd_data_out,
    input  wire logic        tune_done_evt_in,
    input  wire logic        quality_evt_in,
    input  wire logic        data_service_evt_in,
    input  wire logic [2:0]  flag_clear_in,
    input  wire logic        int_mode_in,
    input  wire logic        audio_clock_mode_in,
    output logic             general_out_one_out,
    output logic             general_out_one_oe_out,
    output logic             shared_interrupt_pin_out,
    output logic             shared_interrupt_pin_oe_out,
    output logic             general_out_three_out,
    output logic             general_out_three_oe_out
);
    import gpo_pkg::*;

    // The pin logic is written out for exactly three outputs
    if (PIN_COUNT != 3) begin : g_pin_count
        $error("gpo_ctrl drives exactly three general outputs");
    end
    // Every reset, flag and toggle crossing uses the two-flop gpo_sync
    if (SYNC_STAGES != 2) begin : g_sync_depth
        $error("gpo_ctrl synchronisers are built with two stages only");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: capture one command, hold it until the core acknowledges
    logic            link_rst_n;
    gpo_link_state_t link_state;
    logic [7:0]      hold_code;
    logic [7:0]      hold_arg;
    logic [15:0]     hold_pidx;
    logic [15:0]     hold_pdata;
    logic            req_tgl;
    logic            ack_seen;
    logic            link_ready;
    logic            ack_tgl;
    logic            ack_sync;
    logic [3:0]      flag_sync;
    // Core flags, declared early since the link synchroniser reads them
    logic            err_flag;
    logic            tune_flag;
    logic            qual_flag;
    logic            data_flag;
    logic [15:0]     rd_word;
    logic            link_take;
    logic            link_done;

    gpo_sync #(.WIDTH(1)) u_link_rst (
        .clk_in   (link_clk_in),
        .async_in (rst_n_in),
        .sync_out (link_rst_n)
    );
    gpo_sync #(.WIDTH(5)) u_to_link (
        .clk_in   (link_clk_in),
        .async_in ({ack_tgl, err_flag, data_flag, qual_flag, tune_flag}),
        .sync_out ({ack_sync, flag_sync})
    );

    // Commands offered while busy are ignored; host must wait for send-ready
    assign link_take = cmd_valid_in && (link_state == LINK_READY);
    assign link_done = (link_state == LINK_BUSY) && (ack_sync != ack_seen);

    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n) begin
            link_state       <= LINK_READY;
            hold_code        <= 8'h00;
            hold_arg         <= 8'h00;
            hold_pidx        <= 16'h0000;
            hold_pdata       <= 16'h0000;
            req_tgl          <= 1'b0;
            ack_seen         <= 1'b0;
            link_ready       <= 1'b1;
            prop_rd_data_out <= 16'h0000;
        end else begin
            unique case (link_state)
                LINK_READY: begin
                    if (link_take) begin
                        hold_code  <= cmd_code_in;
                        hold_arg   <= cmd_arg_in;
                        hold_pidx  <= prop_index_in;
                        hold_pdata <= prop_data_in;
                        req_tgl    <= ~req_tgl;
                        link_ready <= 1'b0;
                        link_state <= LINK_BUSY;
                    end
                end
                LINK_BUSY: begin
                    if (link_done) begin
                        ack_seen         <= ack_sync;
                        prop_rd_data_out <= rd_word;
                        link_ready       <= 1'b1;
                        link_state       <= LINK_READY;
                    end
                end
            endcase
        end
    end

    // Status byte seen by the host
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n) begin
            status_out <= 8'h00;
        end else begin
            status_out <= {link_ready, flag_sync[3], 3'b000, flag_sync[2:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: decode and execute
    gpo_core_state_t core_state;
    logic            req_sync;
    logic            req_seen;
    logic            powered;
    logic [2:0]      pin_en;
    logic [2:0]      pin_lvl;
    logic [15:0]     irq_cfg;
    logic            cts_flag;
    logic [3:0]      irq_trig;
    logic            irq_pend;

    gpo_sync #(.WIDTH(1)) u_to_core (
        .clk_in   (clk_in),
        .async_in (req_tgl),
        .sync_out (req_sync)
    );

    wire new_cmd  = (req_sync != req_seen);
    wire exec     = new_cmd && (core_state == CORE_IDLE);
    wire is_pu    = (hold_code == CMD_POWER_UP);
    wire is_oe    = (hold_code == CMD_OUT_ENABLE);
    wire is_lvl   = (hold_code == CMD_OUT_LEVEL);
    wire prop_ok  = (hold_pidx == PROP_IRQ_CFG);
    wire is_set   = (hold_code == CMD_SET_PROP) && prop_ok;
    wire is_get   = (hold_code == CMD_GET_PROP) && prop_ok;
    // Anything but power-up is refused with the fault flag until powered
    wire legal    = is_pu || (powered && (is_oe || is_lvl || is_set || is_get));
    wire [2:0] arg_pins = hold_arg[POS_PIN_LSB +: PIN_COUNT];
    wire tune_en  = irq_cfg[POS_TUNE_IRQ_EN];
    wire qual_en  = irq_cfg[POS_QUAL_IRQ_EN];
    wire fault_en = irq_cfg[POS_FAULT_IRQ_EN];
    wire send_en  = irq_cfg[POS_SEND_IRQ_EN];
    wire tune_rep = irq_cfg[POS_TUNE_REPEAT];
    wire qual_rep = irq_cfg[POS_QUAL_REPEAT];
    wire cts_set  = (core_state == CORE_DONE);

    // An already-set flag only re-raises when its repeat bit allows
    wire next_trig_tune  = tune_done_evt_in && tune_en && (!tune_flag || tune_rep);
    wire next_trig_qual  = quality_evt_in && qual_en && (!qual_flag || qual_rep);
    wire next_trig_fault = exec && !legal && fault_en && !err_flag;
    wire next_trig_send  = cts_set && send_en;
    wire next_irq        = (|irq_trig) || (irq_pend && !exec);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            core_state <= CORE_IDLE;
            req_seen   <= 1'b0;
            ack_tgl    <= 1'b0;
            powered    <= 1'b0;
            pin_en     <= 3'h0;
            pin_lvl    <= 3'h0;
            irq_cfg    <= IRQ_CFG_RESET;
            rd_word    <= 16'h0000;
            cts_flag   <= 1'b1;
            err_flag   <= 1'b0;
        end else begin
            unique case (core_state)
                CORE_IDLE: begin
                    if (exec) begin
                        req_seen   <= req_sync;
                        cts_flag   <= 1'b0;
                        err_flag   <= !legal;
                        rd_word    <= (is_get && legal) ? irq_cfg : 16'h0000;
                        core_state <= CORE_DONE;
                        if (legal && is_pu) begin
                            powered                  <= 1'b1;
                            irq_cfg[POS_SEND_IRQ_EN] <= hold_arg[POS_PU_SEND_EN];
                        end
                        if (legal && is_oe) begin
                            pin_en <= arg_pins;
                        end
                        if (legal && is_lvl) begin
                            pin_lvl <= arg_pins;
                        end
                        if (legal && is_set) begin
                            irq_cfg <= hold_pdata & IRQ_CFG_MASK;
                        end
                    end
                end
                CORE_DONE: begin
                    cts_flag   <= 1'b1;
                    ack_tgl    <= ~ack_tgl;
                    core_state <= CORE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags: a set in the same cycle as a clear wins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tune_flag <= 1'b0;
            qual_flag <= 1'b0;
            data_flag <= 1'b0;
            irq_trig  <= 4'h0;
            irq_pend  <= 1'b0;
        end else begin
            tune_flag <= tune_done_evt_in || (tune_flag && !flag_clear_in[0]);
            qual_flag <= quality_evt_in || (qual_flag && !flag_clear_in[1]);
            data_flag <= data_service_evt_in || (data_flag && !flag_clear_in[2]);
            // Trigger registered with the flag, so irq_pend follows a cycle later and the pin two cycles later
            irq_trig  <= {next_trig_send, next_trig_fault, next_trig_qual, next_trig_tune};
            irq_pend  <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins: special functions first, then enable gates level on outputs one and three
    wire       two_is_irq   = int_mode_in;
    wire       three_is_clk = audio_clock_mode_in;
    wire       next_one_oe  = pin_en[0];
    wire       next_two_oe  = two_is_irq ? 1'b1 : pin_en[1];
    wire       next_two_o   = two_is_irq ? !irq_pend : pin_lvl[1];
    wire       next_thr_oe  = three_is_clk ? 1'b0 : pin_en[2];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            general_out_one_out         <= 1'b0;
            general_out_one_oe_out      <= 1'b0;
            shared_interrupt_pin_out    <= 1'b1;
            shared_interrupt_pin_oe_out <= 1'b0;
            general_out_three_out       <= 1'b0;
            general_out_three_oe_out    <= 1'b0;
        end else begin
            general_out_one_out         <= pin_lvl[0] && next_one_oe;
            general_out_one_oe_out      <= next_one_oe;
            shared_interrupt_pin_out    <= next_two_o;
            shared_interrupt_pin_oe_out <= next_two_oe;
            general_out_three_out       <= pin_lvl[2] && next_thr_oe;
            general_out_three_oe_out    <= next_thr_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the core domain
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    wire any_cause = (cts_flag && send_en) || (err_flag && fault_en)
                   || (tune_flag && tune_en) || (qual_flag && qual_en);

    chk_reset_floats: assert property (
        disable iff (1'b0) (!rst_n_in && !int_mode_in) |=>
            !general_out_one_oe_out && !shared_interrupt_pin_oe_out
            && !general_out_three_oe_out)
        else $error("outputs drive right after reset");
    chk_enable_cmd: assert property (
        (exec && legal && is_oe && !audio_clock_mode_in) ##1 !audio_clock_mode_in |=>
            general_out_one_oe_out == $past(arg_pins[0], 2)
            && general_out_three_oe_out == $past(arg_pins[2], 2))
        else $error("output enable not applied two cycles after command");
    chk_level_cmd: assert property (
        (exec && legal && is_lvl) ##1 pin_en[0] |=>
            general_out_one_out == $past(arg_pins[0], 2))
        else $error("output level not applied two cycles after command");
    chk_level_gated: assert property (
        !pin_en[0] |=> !general_out_one_oe_out && !general_out_one_out)
        else $error("level shows on a disabled output");
    chk_pin_override: assert property (
        int_mode_in |=> shared_interrupt_pin_oe_out
            && shared_interrupt_pin_out == !$past(irq_pend))
        else $error("interrupt use does not own output two");
    chk_clock_input: assert property (
        audio_clock_mode_in |=> !general_out_three_oe_out)
        else $error("output three drives while used as clock input");
    chk_flag_first: assert property (
        $rose(irq_pend) |-> $past(any_cause))
        else $error("interrupt raised without an enabled flag set before");
    chk_send_ready: assert property (
        exec |=> !cts_flag ##1 cts_flag)
        else $error("send-ready not cleared then set around a command");
    chk_cfg_reset: assert property (
        disable iff (1'b0) !rst_n_in |=> irq_cfg == IRQ_CFG_RESET)
        else $error("interrupt configuration not reset to zero");
    chk_powerup_cap: assert property (
        exec && is_pu |=> irq_cfg[POS_SEND_IRQ_EN] == $past(hold_arg[POS_PU_SEND_EN]))
        else $error("power-up send-ready enable not captured");
    chk_fault_irq: assert property (
        exec && !legal && !err_flag |=> irq_trig[2] == $past(fault_en))
        else $error("fault interrupt enable not honoured");
    chk_tune_norep: assert property (
        tune_done_evt_in && tune_flag && !tune_rep |=> !irq_trig[0])
        else $error("tune interrupt repeated without repeat bit");
    chk_qual_norep: assert property (
        quality_evt_in && qual_flag && !qual_rep |=> !irq_trig[1])
        else $error("quality interrupt repeated without repeat bit");
    chk_qual_enable: assert property (
        quality_evt_in && !qual_flag |=> irq_trig[1] == $past(qual_en))
        else $error("quality interrupt enable not honoured");
    chk_tune_enable: assert property (
        tune_done_evt_in && !tune_flag |=> irq_trig[0] == $past(tune_en))
        else $error("tune interrupt enable not honoured");
    chk_irq_hold: assert property (
        irq_pend && !exec && !(|irq_trig) |=> irq_pend)
        else $error("pending interrupt dropped without a command");
    chk_irq_ack: assert property (
        exec && !(|irq_trig) |=> !irq_pend)
        else $error("pending interrupt survives the next command");
    chk_refused_noop: assert property (
        exec && !legal |=> $stable(pin_en) && $stable(pin_lvl) && $stable(irq_cfg))
        else $error("refused command changed configuration");
    chk_three_float: assert property (
        !pin_en[2] |=> !general_out_three_oe_out && !general_out_three_out)
        else $error("level shows on disabled output three");
    chk_level_three: assert property (
        (exec && legal && is_lvl) ##1 (pin_en[2] && !audio_clock_mode_in) |=>
            general_out_three_out == $past(arg_pins[2], 2))
        else $error("output three level not applied after command");
    chk_core_reset: assert property (
        disable iff (1'b0) !rst_n_in |=> cts_flag && !err_flag && !irq_pend)
        else $error("send-ready, fault or pending wrong after reset");

    cov_enable_cmd: cover property (exec && legal && is_oe);
    cov_irq_raised: cover property ($rose(irq_pend));
    cov_tune_repeat: cover property (tune_done_evt_in && tune_flag && tune_rep);
    cov_refused_cmd: cover property (exec && !legal);
    cov_send_irq: cover property (next_trig_send);
endmodule
`default_nettype wire

// ### src/gpo_pkg.sv
// Purpose: Constants for the general output pins and interrupt source block
// Assumes: Commands arrive already framed as code, argument and property words
// Notes:   Bit positions follow the command argument and property layouts
// Contract
// - Command byte 0x80 is output enable with one argument byte
// - Argument bits 3..1 enable outputs three..one; zero means high impedance
// - After reset all three outputs float until commanded
// - Device sets clear-to-send after each command; host waits for it
// - Interrupt use of output two, clock use of three, override settings
// - Command byte 0x81 sets levels; bits 3..1, zero low, one high
// - A level reaches a pin only when that pin is enabled; output two carries its level while disabled
// - Status byte: bit7 send-ready, bit6 fault, bits 2..0 event flags
// - Property 0x0001 selects which status flags drive the interrupt pin
// - A status flag is set before its interrupt is asserted
// - Bit 7 holds send-ready enable from power-up, readable and rewritable
// - Bit 6 enables interrupt on fault flag, default off
// - Bit 3 enables interrupt on signal-quality flag, default off
// - Bit 0 enables interrupt on tune-done flag, default off
// - Bit 11 repeat: quality event interrupts again while flag set
// - Bit 8 repeat: tune event interrupts again while flag set
// - Interrupt configuration resets to 0x0000; accessed only when powered up
package gpo_pkg;
    localparam logic [7:0]  CMD_POWER_UP   = 8'h01;
    localparam logic [7:0]  CMD_SET_PROP   = 8'h12;
    localparam logic [7:0]  CMD_GET_PROP   = 8'h13;
    localparam logic [7:0]  CMD_OUT_ENABLE = 8'h80;
    localparam logic [7:0]  CMD_OUT_LEVEL  = 8'h81;
    localparam logic [15:0] PROP_IRQ_CFG   = 16'h0001;
    localparam logic [15:0] IRQ_CFG_RESET  = 16'h0000;
    localparam logic [15:0] IRQ_CFG_MASK   = 16'h09c9;
    localparam int POS_TUNE_IRQ_EN   = 0;
    localparam int POS_QUAL_IRQ_EN   = 3;
    localparam int POS_FAULT_IRQ_EN  = 6;
    localparam int POS_SEND_IRQ_EN   = 7;
    localparam int POS_TUNE_REPEAT   = 8;
    localparam int POS_QUAL_REPEAT   = 11;
    localparam int POS_PU_SEND_EN    = 7;
    localparam int POS_PIN_LSB       = 1;
    localparam int ST_SEND_READY     = 7;
    localparam int ST_FAULT          = 6;
    localparam int ST_DATA_SERVICE   = 2;
    localparam int ST_QUALITY        = 1;
    localparam int ST_TUNE_DONE      = 0;
    localparam int SYNC_STAGES       = 2;
    localparam int PIN_COUNT         = 3;
    typedef enum logic [0:0] {
        CORE_IDLE = 1'b0,
        CORE_DONE = 1'b1
    } gpo_core_state_t;
    typedef enum logic [0:0] {
        LINK_READY = 1'b0,
        LINK_BUSY  = 1'b1
    } gpo_link_state_t;
endpackage

// ### src/gpo_sync.sv
// Purpose: Two-stage level synchroniser into the destination clock
// Assumes: Each bit is an independent level or a toggle
// Notes:   No reset so the first stage is read by the second only
`timescale 1ns/1ps
`default_nettype none
module gpo_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;
    if (WIDTH < 1) begin : g_width_check
        $error("gpo_sync needs WIDTH of at least one");
    end
    always_ff @(posedge clk_in) begin
        stage_one <= async_in;
        sync_out  <= stage_one;
    end
endmodule
`default_nettype wire

// ### verification/gpo_host_model.sv
// Purpose: Host controller model on the command link
// Assumes: Link clock runs free; requests change just after its rising edge
// Notes:   Released command lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module gpo_host_model (
    input  wire logic        link_clk_in,
    input  wire logic [7:0]  status_in,
    output logic             cmd_valid_out,
    output logic      [7:0]  cmd_code_out,
    output logic      [7:0]  cmd_arg_out,
    output logic      [15:0] prop_index_out,
    output logic      [15:0] prop_data_out
);
    event done_ev;
    int   hang = 0;
    initial begin
        cmd_valid_out = 1'b0;
        {cmd_code_out, cmd_arg_out, prop_index_out, prop_data_out} = '1;
    end
    task automatic send(input logic [7:0] code, input logic [7:0] arg,
                        input logic [15:0] idx, input logic [15:0] data);
        int n;
        n = 0;
        // Wait up to 200 link cycles for send-ready before offering
        while (status_in[7] !== 1'b1 && n < 200) begin
            @(posedge link_clk_in);
            n++;
        end
        #1;
        {cmd_code_out, cmd_arg_out, prop_index_out, prop_data_out} = {code, arg, idx, data};
        cmd_valid_out = 1'b1;
        @(posedge link_clk_in);
        #1;
        cmd_valid_out = 1'b0;
        {cmd_code_out, cmd_arg_out, prop_index_out, prop_data_out} = ~{code, arg, idx, data};
        n = 0;
        while (status_in[7] !== 1'b0 && n < 6) begin
            @(posedge link_clk_in);
            n++;
        end
        if (n == 6) hang++;
        n = 0;
        // Next command only once send-ready is back
        while (status_in[7] !== 1'b1 && n < 40) begin
            @(posedge link_clk_in);
            n++;
        end
        if (n == 40) hang++;
        ->done_ev;
    endtask
endmodule
`default_nettype wire

// ### verification/test_general_output_and_irq_config.sv
// Purpose: Self-checking bench for the general output and irq source block
// Assumes: Host model drives the link; events and mode pins come from here
// Notes:   Expected responses and pin states go through two queues
`timescale 1ns/1ps
`default_nettype none
module test_general_output_and_irq_config;
    import gpo_pkg::*;
    logic        clk_in = 0, link_clk_in = 0, rst_n_in = 0;
    logic        int_mode = 0, audio_mode = 0, tune_evt = 0, qual_evt = 0, ds_evt = 0;
    logic [2:0]  flag_clear = 0, flags = 0;
    logic        cmd_valid, fault = 0, powered = 0;
    logic [7:0]  cmd_code, cmd_arg, status;
    logic [15:0] prop_index, prop_data, prop_rd, cfg = 0;
    logic [3:1]  en = 0, lv = 0;
    logic [5:0]  pin_seen;
    logic [23:0] cmd_q[$];
    logic [11:0] pin_q[$];
    event        pin_ev;
    int          num_errors = 0, comparisons = 0, cycles = 0, seed;
    initial forever #2 clk_in = ~clk_in;
    initial begin
        #1.3;
        forever #3 link_clk_in = ~link_clk_in;
    end
    gpo_host_model host (.link_clk_in(link_clk_in), .status_in(status),
        .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code), .cmd_arg_out(cmd_arg),
        .prop_index_out(prop_index), .prop_data_out(prop_data));
    gpo_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
        .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_arg_in(cmd_arg),
        .prop_index_in(prop_index), .prop_data_in(prop_data), .status_out(status),
        .prop_rd_data_out(prop_rd), .tune_done_evt_in(tune_evt), .quality_evt_in(qual_evt),
        .data_service_evt_in(ds_evt), .flag_clear_in(flag_clear), .int_mode_in(int_mode),
        .audio_clock_mode_in(audio_mode), .general_out_one_out(pin_seen[0]),
        .general_out_one_oe_out(pin_seen[3]), .shared_interrupt_pin_out(pin_seen[1]),
        .shared_interrupt_pin_oe_out(pin_seen[4]), .general_out_three_out(pin_seen[2]),
        .general_out_three_oe_out(pin_seen[5]));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors + host.hang, comparisons);
        if (num_errors + host.hang == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp_resp(input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED response expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_pins(input logic [5:0] e, input logic [5:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED pins expected %h seen %h", e, g);
        end
    endtask
    // Expectation is worked out before the host sends the command
    task automatic cmd(input logic [7:0] code, input logic [7:0] arg,
                       input logic [15:0] idx, input logic [15:0] data);
        logic ok;
        logic [15:0] rd;
        ok = powered ? (code inside {8'h01, 8'h80, 8'h81} ||
             (code inside {8'h12, 8'h13} && idx == 16'h0001)) : code == 8'h01;
        rd = 16'h0000;
        if (ok && code == 8'h01) begin
            powered = 1'b1;
            cfg[7] = arg[7];
        end
        if (ok && code == 8'h12) cfg = data & IRQ_CFG_MASK;
        if (ok && code == 8'h13) rd = cfg;
        if (ok && code == 8'h80) en = arg[3:1];
        if (ok && code == 8'h81) lv = arg[3:1];
        fault = !ok;
        cmd_q.push_back({1'b1, fault, 3'h0, flags, rd});
        host.send(code, arg, idx, data);
    endtask
    task automatic pins(input logic pend);
        logic [5:0] e;
        logic [5:0] m;
        e = {en[3] & ~audio_mode, int_mode | en[2], en[1], lv[3], int_mode ? ~pend : lv[2], lv[1]};
        m = {3'h7, e[5:3]};
        pin_q.push_back({m, e & m});
        ->pin_ev;
    endtask
    task automatic pulse(input int k, input logic clr);
        @(posedge clk_in);
        #1;
        if (clr) flag_clear[k] = 1'b1;
        else {ds_evt, qual_evt, tune_evt} = 3'h1 << k;
        @(posedge clk_in);
        #1;
        {ds_evt, qual_evt, tune_evt, flag_clear} = 6'h00;
        flags[k] = ~clr;
        repeat (6) @(posedge clk_in);
    endtask
    always @(host.done_ev) begin
        logic [23:0] n;
        n = cmd_q.pop_front();
        cmp_resp(n, {status, prop_rd});
    end
    always @(pin_ev) begin
        logic [11:0] n;
        n = pin_q.pop_front();
        cmp_pins(n[5:0], pin_seen & n[11:6]);
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(19);
        // Longer than three cycles so the link side sees four edges too
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (2) @(posedge clk_in);
        pins(1'b0);
        cmd(8'h80, 8'h0e, 16'h0, 16'h0);
        pins(1'b0);
        cmd(8'h01, 8'h80, 16'h0, 16'h0);
        cmd(8'h13, 8'h00, 16'h0001, 16'h0);
        cmd(8'h12, 8'h00, 16'h0002, 16'h0080);
        cmd(8'h12, 8'h00, 16'h0001, 16'hffff);
        cmd(8'h13, 8'h00, 16'h0001, 16'h0);
        cmd(8'h12, 8'h00, 16'h0001, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            cmd(8'h81, {4'h0, 3'($urandom), 1'b0}, 16'h0, 16'h0);
            cmd(8'h80, {4'h0, 3'(i), 1'b0}, 16'h0, 16'h0);
            pins(1'b0);
        end
        @(posedge clk_in) #1 int_mode = 1'b1;
        // Pin registers follow the mode one edge later
        repeat (2) @(posedge clk_in);
        pins(1'b0);
        cmd(8'h12, 8'h00, 16'h0001, 16'h0080);
        repeat (10) @(posedge clk_in);
        pins(1'b1);
        cmd(8'h12, 8'h00, 16'h0001, 16'h0000);
        cmd(8'h13, 8'h00, 16'h0001, 16'h0);
        pins(1'b0);
        // Tune then quality: enable, repeat suppressed, repeat allowed
        for (int k = 0; k < 2; k++) begin
            cmd(8'h12, 8'h00, 16'h0001, k ? 16'h0008 : 16'h0001);
            pulse(k, 1'b0);
            pins(1'b1);
            cmd(8'h13, 8'h00, 16'h0001, 16'h0);
            pins(1'b0);
            pulse(k, 1'b0);
            pins(1'b0);
            cmd(8'h12, 8'h00, 16'h0001, k ? 16'h0808 : 16'h0101);
            pulse(k, 1'b0);
            pins(1'b1);
            cmd(8'h13, 8'h00, 16'h0001, 16'h0);
            pulse(k, 1'b1);
        end
        cmd(8'h12, 8'h00, 16'h0001, 16'h0040);
        cmd(8'h55, 8'h00, 16'h0, 16'h0);
        repeat (6) @(posedge clk_in);
        pins(1'b1);
        cmd(8'h13, 8'h00, 16'h0001, 16'h0);
        pins(1'b0);
        pulse(2, 1'b0);
        pins(1'b0);
        cmd(8'h13, 8'h00, 16'h0001, 16'h0);
        pulse(2, 1'b1);
        @(posedge clk_in) #1 {int_mode, audio_mode} = 2'b01;
        cmd(8'h81, 8'h0e, 16'h0, 16'h0);
        cmd(8'h80, 8'h0e, 16'h0, 16'h0);
        pins(1'b0);
        @(posedge clk_in) #1 audio_mode = 1'b0;
        repeat (2) @(posedge clk_in);
        pins(1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
